// [hw/vbiwc_defines.vh]
// Register map, field positions and reset values of the line window and control word bank
`ifndef VBIWC_DEFINES_VH
`define VBIWC_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define VBIWC_IDX_EVEN_FIRST 12'h134
`define VBIWC_IDX_EVEN_LAST 12'h135
`define VBIWC_IDX_ODD_FIRST 12'h136
`define VBIWC_IDX_ODD_LAST 12'h137
`define VBIWC_IDX_WIN_CTRL 12'h138
`define VBIWC_IDX_SLICER 12'h139
`define VBIWC_IDX_CTRL 12'h140
`define VBIWC_IDX_STATUS 12'h141
`define VBIWC_IDX_DECIM 12'h142
`define VBIWC_IDX_LINE 12'h143
`define VBIWC_IDX_REFLEN 12'h144

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define VBIWC_RST_EVEN_FIRST 12'h110
`define VBIWC_RST_EVEN_LAST 12'h11B
`define VBIWC_RST_ODD_FIRST 12'h00A
`define VBIWC_RST_ODD_LAST 12'h015
`define VBIWC_RST_ZERO 12'h000
`define VBIWC_SLICER_DEFAULT 12'h040
`define VBIWC_RST_REFLEN 12'h120

// ----------------------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------------------
`define VBIWC_CW_SYNC 1:0
`define VBIWC_CW_REFMODE 2
`define VBIWC_CW_WIN1 5
`define VBIWC_CW_WIN2 6
`define VBIWC_CW_DECIM 10
`define VBIWC_CW_TIMING 11
`define VBIWC_CW_KEEP 12'h007

// Sync timing modes
`define VBIWC_SYNC_TRACK 2'h0
`define VBIWC_SYNC_CORRECT 2'h1
`define VBIWC_SYNC_FREE 2'h2

// AHB-Lite encodings
`define VBIWC_HTRANS_NONSEQ 2'h2
`define VBIWC_HSIZE_WORD 3'h2
`define VBIWC_ADDR_IDX 13:2

`endif

// [hw/vbiwc_bank.v]
// Line window, slicer size and control word register bank behind an AHB-Lite slave
// ----------------------------------------------------------------------------
// Function
// - Even window start from even start register
// - Even line numbers count across whole frame
// - Even window end from even end register
// - Odd window start from odd start register
// - Odd window end from odd end register
// - Slicer size zero means sixty-four
// - Control bits 1:0 select sync mode
// - Corrected tracking fixes out-of-tolerance timing
// - Scan mode syncs run free
// - Bit 2 selects reference length mode
// - Bits 5/6 commit windows, self-clearing
// - Bit 10 commits decimation count, self-clearing
// - Bit 11 commits sync mode, self-clearing
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "vbiwc_defines.vh"

module vbiwc_bank (
  input wire CLOCK,
  input wire RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire [11:0] LINE_NUM,
  input wire FIELD_ODD,
  input wire LINE_STROBE,
  input wire SYNC_IN_OK,
  output reg IN_WINDOW,
  output reg ACTIVE_VIDEO_REF,
  output reg [1:0] SYNC_MODE,
  output reg SYNC_FREE_RUN,
  output reg SYNC_CORRECT,
  output reg [11:0] SLICER_SIZE,
  output reg [11:0] DECIM_FRAMES,
  output reg COMMIT_WINDOW_ONE,
  output reg COMMIT_WINDOW_TWO
);

  // --------------------------------------------------------------------------
  // Bus address phase capture
  // --------------------------------------------------------------------------
  reg wr_pend_r;
  reg rd_pend_r;
  reg [11:0] idx_r;
  // HSIZE is ignored: every register is one whole word, so a narrow
  // access is handled as a word access
  wire take = HSEL && HREADY && (HTRANS == `VBIWC_HTRANS_NONSEQ);

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r <= `VBIWC_RST_ZERO;
    end else begin
      wr_pend_r <= take && HWRITE;
      rd_pend_r <= take && !HWRITE;
      // Only the word index is decoded, so higher address bits alias
      if (take) begin
        idx_r <= HADDR[`VBIWC_ADDR_IDX];
      end
    end
  end

  // Write decode for the data phase: the index came with the address phase
  // and HWDATA stands now
  wire [11:0] wd = HWDATA[11:0];
  wire wr_ef = wr_pend_r && (idx_r == `VBIWC_IDX_EVEN_FIRST);
  wire wr_el = wr_pend_r && (idx_r == `VBIWC_IDX_EVEN_LAST);
  wire wr_of = wr_pend_r && (idx_r == `VBIWC_IDX_ODD_FIRST);
  wire wr_ol = wr_pend_r && (idx_r == `VBIWC_IDX_ODD_LAST);
  wire wr_wc = wr_pend_r && (idx_r == `VBIWC_IDX_WIN_CTRL);
  wire wr_sl = wr_pend_r && (idx_r == `VBIWC_IDX_SLICER);
  wire wr_cw = wr_pend_r && (idx_r == `VBIWC_IDX_CTRL);
  wire wr_dc = wr_pend_r && (idx_r == `VBIWC_IDX_DECIM);
  wire wr_rl = wr_pend_r && (idx_r == `VBIWC_IDX_REFLEN);

  // --------------------------------------------------------------------------
  // Pin synchronisers for the video timing inputs
  // --------------------------------------------------------------------------
  // Each pin passes two flops; the strobe edge is taken from the second
  // stage only, so a metastable first stage never makes a false line
  reg [11:0] line_s1_r;
  reg [11:0] line_s2_r;
  reg [2:0] pin_s1_r;
  reg [2:0] pin_s2_r;
  reg strobe_d_r;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      line_s1_r <= `VBIWC_RST_ZERO;
      line_s2_r <= `VBIWC_RST_ZERO;
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      strobe_d_r <= 1'b0;
    end else begin
      line_s1_r <= LINE_NUM;
      line_s2_r <= line_s1_r;
      pin_s1_r <= {SYNC_IN_OK, LINE_STROBE, FIELD_ODD};
      pin_s2_r <= pin_s1_r;
      strobe_d_r <= pin_s2_r[1];
    end
  end

  wire field_odd = pin_s2_r[0];
  wire line_tick = pin_s2_r[1] && !strobe_d_r;
  wire sync_ok = pin_s2_r[2];

  // --------------------------------------------------------------------------
  // Line capture
  // --------------------------------------------------------------------------
  // The line number is a multi-bit word from another domain and its bits may
  // settle at different edges. It is taken a full cycle after the synced
  // strobe edge, so LINE_NUM may still settle up to a cycle after the strobe rises.
  // Between strobes the window logic sees one steady, coherent word.
  reg tick_d_r;
  reg field_r;
  reg [11:0] line_r;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tick_d_r <= 1'b0;
      field_r <= 1'b0;
      line_r <= `VBIWC_RST_ZERO;
    end else begin
      tick_d_r <= line_tick;
      if (tick_d_r) begin
        field_r <= field_odd;
        line_r <= line_s2_r;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software-written registers
  // --------------------------------------------------------------------------
  reg [11:0] even_first_r;
  reg [11:0] even_last_r;
  reg [11:0] odd_first_r;
  reg [11:0] odd_last_r;
  reg [11:0] win_ctrl_r;
  reg [11:0] slicer_r;
  reg [11:0] ctrl_r;
  reg [11:0] decim_stage_r;
  reg [11:0] ref_len_r;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      even_first_r <= `VBIWC_RST_EVEN_FIRST;
      even_last_r <= `VBIWC_RST_EVEN_LAST;
      odd_first_r <= `VBIWC_RST_ODD_FIRST;
      odd_last_r <= `VBIWC_RST_ODD_LAST;
      win_ctrl_r <= `VBIWC_RST_ZERO;
      slicer_r <= `VBIWC_RST_ZERO;
      ctrl_r <= `VBIWC_RST_ZERO;
      decim_stage_r <= `VBIWC_RST_ZERO;
      ref_len_r <= `VBIWC_RST_REFLEN;
    end else begin
      if (wr_ef) even_first_r <= wd;
      if (wr_el) even_last_r <= wd;
      if (wr_of) odd_first_r <= wd;
      if (wr_ol) odd_last_r <= wd;
      if (wr_wc) win_ctrl_r <= wd;
      if (wr_sl) slicer_r <= wd;
      if (wr_dc) decim_stage_r <= wd;
      if (wr_rl) ref_len_r <= wd;
      // Strobe bits are never stored, so they always read back zero
      if (wr_cw) begin
        ctrl_r <= wd & `VBIWC_CW_KEEP;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Committed settings and strobes
  // --------------------------------------------------------------------------
  // Window limits in use; the committed copies change only on a commit strobe
  // so a half-written window never reaches the slicer.
  reg [11:0] act_ef_r;
  reg [11:0] act_el_r;
  reg [11:0] act_of_r;
  reg [11:0] act_ol_r;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      act_ef_r <= `VBIWC_RST_EVEN_FIRST;
      act_el_r <= `VBIWC_RST_EVEN_LAST;
      act_of_r <= `VBIWC_RST_ODD_FIRST;
      act_ol_r <= `VBIWC_RST_ODD_LAST;
      COMMIT_WINDOW_ONE <= 1'b0;
      COMMIT_WINDOW_TWO <= 1'b0;
      DECIM_FRAMES <= `VBIWC_RST_ZERO;
      SYNC_MODE <= `VBIWC_SYNC_TRACK;
      SLICER_SIZE <= `VBIWC_SLICER_DEFAULT;
    end else begin
      // A write with both bits set copies the limits once and pulses both
      COMMIT_WINDOW_ONE <= wr_cw && wd[`VBIWC_CW_WIN1];
      COMMIT_WINDOW_TWO <= wr_cw && wd[`VBIWC_CW_WIN2];
      if (wr_cw && (wd[`VBIWC_CW_WIN1] || wd[`VBIWC_CW_WIN2])) begin
        act_ef_r <= even_first_r;
        act_el_r <= even_last_r;
        act_of_r <= odd_first_r;
        act_ol_r <= odd_last_r;
      end
      // The staged count reaches the decimation logic only on its latch
      if (wr_cw && wd[`VBIWC_CW_DECIM]) DECIM_FRAMES <= decim_stage_r;
      if (wr_cw && wd[`VBIWC_CW_TIMING]) SYNC_MODE <= wd[`VBIWC_CW_SYNC];
      // Zero stands for the default size
      SLICER_SIZE <= (slicer_r == `VBIWC_RST_ZERO) ? `VBIWC_SLICER_DEFAULT : slicer_r;
    end
  end

  // --------------------------------------------------------------------------
  // Sync behaviour, window and reference
  // --------------------------------------------------------------------------
  // Line numbers arrive frame-relative in both fields, so the even limits
  // compare directly against the frame line count.
  wire [11:0] w_first = field_r ? act_of_r : act_ef_r;
  wire [11:0] w_last = field_r ? act_ol_r : act_el_r;
  wire in_win = (line_r >= w_first) && (line_r <= w_last);
  // Window start for the line being captured, so the count loads with it
  wire [11:0] start_now = field_odd ? act_of_r : act_ef_r;
  reg [11:0] ref_cnt_r;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      IN_WINDOW <= 1'b0;
      ACTIVE_VIDEO_REF <= 1'b0;
      ref_cnt_r <= `VBIWC_RST_ZERO;
      SYNC_FREE_RUN <= 1'b0;
      SYNC_CORRECT <= 1'b0;
    end else begin
      IN_WINDOW <= in_win;
      SYNC_FREE_RUN <= (SYNC_MODE == `VBIWC_SYNC_FREE);
      // Correction is flagged only while the synced input is out of tolerance
      SYNC_CORRECT <= (SYNC_MODE == `VBIWC_SYNC_CORRECT) && !sync_ok;
      if (ctrl_r[`VBIWC_CW_REFMODE]) begin
        // Programmed length counts lines from the window start of each field; it may
        // run past the window end, so the reference can cover lines after the window
        if (tick_d_r) begin
          if (line_s2_r == start_now) begin
            ref_cnt_r <= ref_len_r;
          end else if (ref_cnt_r != `VBIWC_RST_ZERO) begin
            ref_cnt_r <= ref_cnt_r - 12'h001;
          end
        end
        ACTIVE_VIDEO_REF <= (ref_cnt_r != `VBIWC_RST_ZERO);
      end else begin
        ACTIVE_VIDEO_REF <= in_win;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bus answer: one wait state on reads, always OKAY
  // --------------------------------------------------------------------------
  // Window and slicer registers are write-only and read back zero
  reg [11:0] rd_nxt;

  always @* begin
    case (idx_r)
      `VBIWC_IDX_CTRL: rd_nxt = ctrl_r;
      `VBIWC_IDX_STATUS: rd_nxt = {8'h00, ctrl_r[`VBIWC_CW_REFMODE], SYNC_FREE_RUN, SYNC_MODE};
      `VBIWC_IDX_DECIM: rd_nxt = DECIM_FRAMES;
      `VBIWC_IDX_LINE: rd_nxt = {IN_WINDOW, field_r, 10'h000} | (line_r & 12'h3FF);
      `VBIWC_IDX_REFLEN: rd_nxt = ref_len_r;
      default: rd_nxt = `VBIWC_RST_ZERO;
    endcase
  end

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HRESP <= 1'b0;
      // Read data is registered a cycle after the address phase, so a write
      // in the preceding data phase is already stored; the cost is one wait
      // state on every read. HRDATA then stands through the final data edge.
      HREADYOUT <= !(take && !HWRITE);
      if (rd_pend_r) begin
        HRDATA <= {20'h00000, rd_nxt};
      end
    end
  end

endmodule // vbiwc_bank

`default_nettype wire

// [test/vbiwc_asserts.sv]
// Concurrent checks on the bank's bus and control outputs
`timescale 1ns/10ps
`default_nettype none
`include "vbiwc_defines.vh"
module vbiwc_asserts (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic [1:0] SYNC_MODE,
  input wire logic SYNC_FREE_RUN,
  input wire logic [11:0] SLICER_SIZE,
  input wire logic [11:0] DECIM_FRAMES,
  input wire logic COMMIT_WINDOW_ONE,
  input wire logic COMMIT_WINDOW_TWO
);
  // ---------------------------------------------------------------
  // Control word write and bus read tracking
  // ---------------------------------------------------------------
  // High in the data phase of a control write, when its data stands
  logic wc_r;
  logic rd_r;
  wire c5 = wc_r & HWDATA[5], c6 = wc_r & HWDATA[6], c10 = wc_r & HWDATA[10], c11 = wc_r & HWDATA[11];
  always @(posedge CLOCK or posedge RST) begin
    if (RST) wc_r <= 1'b0;
    else wc_r <= HSEL & HREADY & (HTRANS == 2'h2) & HWRITE & (HADDR[13:2] == `VBIWC_IDX_CTRL);
  end
  // High in the data phase of a read, the one cycle the bank holds the bus
  always @(posedge CLOCK or posedge RST) begin
    if (RST) rd_r <= 1'b0;
    else rd_r <= HSEL & HREADY & (HTRANS == 2'h2) & !HWRITE;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_ready_high: assert property (HREADYOUT == !rd_r) else $error("read wait state wrong");
  a_slicer_nonzero: assert property (SLICER_SIZE != 12'h000) else $error("slicer size zero");
  a_free_run: assert property ($stable(SYNC_MODE) |-> SYNC_FREE_RUN == (SYNC_MODE == 2'h2))
    else $error("free run flag wrong");
  a_mode_latch: assert property ($changed(SYNC_MODE) |-> $past(c11) || $past(c11, 2))
    else $error("sync mode moved without latch");
  a_decim_latch: assert property ($changed(DECIM_FRAMES) |-> $past(c10) || $past(c10, 2))
    else $error("decimation moved without latch");
  a_win1_pulse: assert property (c5 |-> ##[1:2] COMMIT_WINDOW_ONE) else $error("no window one commit");
  a_win2_pulse: assert property (c6 |-> ##[1:2] COMMIT_WINDOW_TWO) else $error("no window two commit");
  a_win1_cause: assert property ($rose(COMMIT_WINDOW_ONE) |-> $past(c5) || $past(c5, 2))
    else $error("stray window one commit");
endmodule // vbiwc_asserts
`default_nettype wire

// [test/vbiwc_bank_tb.sv]
// Self-checking bench of the line window and control word bank
`timescale 1ns/10ps
`default_nettype none
`include "vbiwc_defines.vh"
module vbiwc_bank_tb;
  localparam logic [11:0] CW = `VBIWC_IDX_CTRL;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwr = 1'b0, odd = 1'b0, lstb = 1'b0, s_ok = 1'b1;
  logic [1:0] htr = 2'h0;
  logic [11:0] lnum = 12'h000;
  logic [31:0] hadr = 32'h0, hwd = 32'h0;
  wire logic [31:0] hrd;
  wire logic [11:0] slsz, decim;
  wire logic [1:0] smode;
  wire logic rdy, resp, inw, avr, frun, scor, cw1, cw2;
  integer n_fail = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  vbiwc_bank u_vbiwc_bank (.CLOCK(clk), .RST(rst), .HSEL(hsel), .HADDR(hadr), .HTRANS(htr), .HWRITE(hwr),
    .HSIZE(3'h2), .HWDATA(hwd), .HREADY(rdy), .HRDATA(hrd), .HREADYOUT(rdy), .HRESP(resp), .LINE_NUM(lnum),
    .FIELD_ODD(odd), .LINE_STROBE(lstb), .SYNC_IN_OK(s_ok), .IN_WINDOW(inw), .ACTIVE_VIDEO_REF(avr),
    .SYNC_MODE(smode), .SYNC_FREE_RUN(frun), .SYNC_CORRECT(scor), .SLICER_SIZE(slsz), .DECIM_FRAMES(decim),
    .COMMIT_WINDOW_ONE(cw1), .COMMIT_WINDOW_TWO(cw2));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      if (rdy === 1'b1) return;
    end
    n_fail++;
    complete_run();
  endtask
  // Reads insert one wait state; the second wait_rdy absorbs it and read data is taken at that edge
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    hadr <= {18'h0, idx, 2'h0};
    htr <= 2'h2;
    hwr <= w;
    wait_rdy();
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= wd;
    wait_rdy();
    rd = hrd;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [11:0] d);
    logic [31:0] x;
    bus(1'b1, idx, {20'h0, (idx == CW) ? (d & 12'hDE7) : d}, x);
  endtask
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask
  // One strobe pulse per line; eight cycles cover the sync, the capture and the output register
  task automatic step(input logic f, input logic [11:0] n);
    @(posedge clk);
    odd <= f;
    lnum <= n;
    lstb <= 1'b1;
    repeat (2) @(posedge clk);
    lstb <= 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic ln(input logic f, input logic [11:0] n, input logic e);
    step(f, n);
    chk(inw, e);
    chk(avr, e);
  endtask
  task automatic probe(input logic [11:0] ef, el, of, ol);
    ln(1'b0, ef - 12'h1, 1'b0);
    ln(1'b0, ef, 1'b1);
    ln(1'b0, el, 1'b1);
    ln(1'b0, el + 12'h1, 1'b0);
    ln(1'b1, of - 12'h1, 1'b0);
    ln(1'b1, of, 1'b1);
    ln(1'b1, ol, 1'b1);
    ln(1'b1, ol + 12'h1, 1'b0);
    ln(1'b1, ef, 1'b0);
    ln(1'b0, of, 1'b0);
  endtask
  task automatic t_window();
    probe(12'h110, 12'h11B, 12'h00A, 12'h015);
    wr(`VBIWC_IDX_EVEN_FIRST, 12'h200);
    wr(`VBIWC_IDX_EVEN_LAST, 12'h202);
    wr(`VBIWC_IDX_ODD_FIRST, 12'h030);
    wr(`VBIWC_IDX_ODD_LAST, 12'h030);
    ln(1'b0, 12'h201, 1'b0);
    wr(CW, 12'h020);
    @(negedge clk);
    chk({cw1, cw2}, 2'h2);
    @(negedge clk);
    chk(cw1, 1'b0);
    probe(12'h200, 12'h202, 12'h030, 12'h030);
    wr(CW, 12'h040);
    @(negedge clk);
    chk({cw1, cw2}, 2'h1);
  endtask
  task automatic t_ref();
    logic [31:0] x;
    wr(`VBIWC_IDX_REFLEN, 12'h002);
    wr(CW, 12'h004);
    bus(1'b0, CW, 32'h0, x);
    chk(x, 32'h4);
    step(1'b1, 12'h02F);
    chk(avr, 1'b0);
    step(1'b1, 12'h030);
    chk(avr, 1'b1);
    step(1'b1, 12'h031);
    chk({inw, avr}, 2'h1);
    step(1'b1, 12'h032);
    chk(avr, 1'b0);
    wr(CW, 12'h000);
  endtask
  task automatic t_sync();
    wr(CW, 12'h002);
    settle();
    chk(smode, 2'h0);
    for (int m = 2; m >= 0; m--) begin
      wr(CW, 12'h800 | m[11:0]);
      settle();
      chk(smode, m);
      chk(frun, m == 2);
      @(posedge clk);
      s_ok <= 1'b0;
      settle();
      chk(scor, m == 1);
      @(posedge clk);
      s_ok <= 1'b1;
      settle();
      chk(scor, 1'b0);
    end
  endtask
  task automatic t_regs();
    logic [31:0] x;
    chk(slsz, 12'h040);
    wr(`VBIWC_IDX_DECIM, 12'h007);
    settle();
    chk(decim, 12'h000);
    wr(CW, 12'h402);
    settle();
    chk(decim, 12'h007);
    chk(smode, 2'h0);
    bus(1'b0, `VBIWC_IDX_DECIM, 32'h0, x);
    chk(x, 32'h7);
    bus(1'b0, CW, 32'h0, x);
    chk(x, 32'h2);
    wr(`VBIWC_IDX_SLICER, 12'h025);
    wr(12'h3FF, 12'h000);
    settle();
    chk(slsz, 12'h025);
    bus(1'b0, 12'h3FF, 32'h0, x);
    chk(x, 32'h0);
    wr(`VBIWC_IDX_SLICER, 12'h000);
    settle();
    chk(slsz, 12'h040);
    chk(resp, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_window();
    t_ref();
    t_sync();
    t_regs();
    complete_run();
  end
endmodule // vbiwc_bank_tb
bind vbiwc_bank vbiwc_asserts u_vbiwc_asserts (.CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .SYNC_MODE(SYNC_MODE), .SYNC_FREE_RUN(SYNC_FREE_RUN), .SLICER_SIZE(SLICER_SIZE), .DECIM_FRAMES(DECIM_FRAMES),
  .COMMIT_WINDOW_ONE(COMMIT_WINDOW_ONE), .COMMIT_WINDOW_TWO(COMMIT_WINDOW_TWO));
`default_nettype wire
